// ===== rtl/cps_priority_scheduler.sv
// Overview of operation
// - table maps eight priorities onto four classes
// - serve from highest class, burst, then lower
// - burst limit 0..255, zero drains the class
// - per-queue latency limit in 17 us ticks
// - latency limit zero disables the age timer
// - entries keyed by VLAN and MAC, priority 0 highest
// - entry matches destination, source or either address
// - per-port security enable, address limit, flush mode
// - port default priority for untagged packets
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module cps_priority_scheduler
   import cps_pkg::*;
#(
   parameter int DESC_W = 32,
   parameter int NUM_ENTRIES = 4,
   parameter int QUEUE_DEPTH = FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [DESC_W-1:0] in_desc,
   input wire logic in_has_prio,
   input wire logic [PRIO_W-1:0] in_prio,
   input wire logic [VID_W-1:0] in_vid,
   input wire logic [MAC_W-1:0] in_src_mac,
   input wire logic [MAC_W-1:0] in_dst_mac,
   output logic out_valid,
   input wire logic out_ready,
   output logic [DESC_W-1:0] out_desc,
   output logic [CLASS_W-1:0] out_class,
   input wire logic learn_req,
   output logic learn_ok,
   input wire logic restart
);
   localparam int QW = DESC_W + STAMP_W;

   logic [15:0] class_map_reg;
   logic [DATA_W-1:0] port_cfg_reg;
   logic [DATA_W-1:0] burst_reg;
   logic [DATA_W-1:0] latency_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic [MAC_W-1:0] ent_mac_reg [NUM_ENTRIES];
   logic [VID_W-1:0] ent_vid_reg [NUM_ENTRIES];
   logic [PRIO_W-1:0] ent_prio_reg [NUM_ENTRIES];
   logic [1:0] ent_sel_reg [NUM_ENTRIES];
   logic [NUM_ENTRIES-1:0] ent_wr;
   logic [NUM_ENTRIES-1:0] ent_match;
   logic [ADDR_W-1:0] ent_off;
   logic ent_space;
   logic hit;
   logic [PRIO_W-1:0] hit_prio;
   logic [PRIO_W-1:0] eff_prio;
   logic [CLASS_W-1:0] push_class;
   logic [NUM_CLASS-1:0] q_push;
   logic [NUM_CLASS-1:0] q_in_ready;
   logic [NUM_CLASS-1:0] q_valid;
   logic [NUM_CLASS-1:0] q_pop;
   logic [NUM_CLASS-1:0] urg;
   logic [QW-1:0] q_data [NUM_CLASS];
   logic [TICK_W-1:0] tick_cnt_reg;
   logic tick;
   logic [STAMP_W-1:0] now_reg;
   logic [CLASS_W-1:0] cur_reg;
   logic [LIM_W-1:0] sent_reg;
   logic [CLASS_W-1:0] sel;
   logic sel_fresh;
   logic urg_any;
   logic budget_ok;
   logic deq;
   logic out_valid_reg;
   logic [DESC_W-1:0] out_desc_reg;
   logic [CLASS_W-1:0] out_class_reg;
   logic [LIM_W-1:0] learned_reg;
   logic sec_en;
   logic [LIM_W-1:0] addr_limit;

   assign ent_off = reg_addr - OFF_ENTRY_BASE;
   assign ent_space = reg_addr >= OFF_ENTRY_BASE;
   assign sec_en = port_cfg_reg[CFG_SEC_EN_BIT];
   assign addr_limit = port_cfg_reg[CFG_LIMIT_LSB +: LIM_W];

   // software writes to the plain configuration words
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         class_map_reg <= CLASS_MAP_RST;
         port_cfg_reg <= PORT_CFG_RST;
         burst_reg <= BURST_RST;
         latency_reg <= LATENCY_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == OFF_CLASS_MAP)
         begin
            class_map_reg <= reg_wdata[15:0];
         end
         if (reg_addr == OFF_PORT_CFG)
         begin
            port_cfg_reg <= reg_wdata;
         end
         if (reg_addr == OFF_BURST)
         begin
            burst_reg <= reg_wdata;
         end
         if (reg_addr == OFF_LATENCY)
         begin
            latency_reg <= reg_wdata;
         end
      end
   end

   // priority entries: write decode and address match, one slot each
   generate
      for (genvar i = 0; i < NUM_ENTRIES; i++)
      begin : g_entry
         logic vid_eq;
         logic dst_eq;
         logic src_eq;
         assign ent_wr[i] = reg_wr && ent_space && ent_off[7:4] == 4'(i);
         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               ent_mac_reg[i] <= '0;
               ent_vid_reg[i] <= '0;
               ent_prio_reg[i] <= '0;
               ent_sel_reg[i] <= MATCH_OFF;
            end
            else if (ent_wr[i])
            begin
               if (ent_off[3:2] == ENT_WORD_MAC_LO)
               begin
                  ent_mac_reg[i][31:0] <= reg_wdata;
               end
               if (ent_off[3:2] == ENT_WORD_MISC)
               begin
                  ent_mac_reg[i][MAC_W-1:32] <= reg_wdata[15:0];
                  ent_vid_reg[i] <= reg_wdata[ENT_VID_LSB +: VID_W];
                  ent_prio_reg[i] <= reg_wdata[ENT_PRIO_LSB +: PRIO_W];
               end
               if (ent_off[3:2] == ENT_WORD_SEL)
               begin
                  ent_sel_reg[i] <= reg_wdata[1:0];
               end
            end
         end
         assign vid_eq = ent_vid_reg[i] == in_vid;
         assign dst_eq = ent_mac_reg[i] == in_dst_mac;
         assign src_eq = ent_mac_reg[i] == in_src_mac;
         // selector picks which address of the packet is compared
         always_comb
         begin
            unique case (cps_match_e'(ent_sel_reg[i]))
               MATCH_OFF: ent_match[i] = 1'b0;
               MATCH_DST: ent_match[i] = vid_eq && dst_eq;
               MATCH_SRC: ent_match[i] = vid_eq && src_eq;
               MATCH_EITHER: ent_match[i] = vid_eq && (dst_eq || src_eq);
            endcase
         end
      end
   endgenerate

   // among several matching entries the numerically lowest priority wins
   always_comb
   begin
      hit = 1'b0;
      hit_prio = '1;
      for (int i = 0; i < NUM_ENTRIES; i++)
      begin
         if (ent_match[i] && (!hit || ent_prio_reg[i] < hit_prio))
         begin
            hit = 1'b1;
            hit_prio = ent_prio_reg[i];
         end
      end
   end

   // entry beats the packet's own tag, which beats the port default
   assign eff_prio = hit ? hit_prio
                   : in_has_prio ? in_prio
                   : port_cfg_reg[CFG_DPRIO_LSB +: PRIO_W];
   assign push_class = class_map_reg[{eff_prio, 1'b0} +: CLASS_W];
   assign in_ready = q_in_ready[push_class];

   // free-running tick of the latency unit and a coarse time stamp
   assign tick = tick_cnt_reg == TICK_W'(TICK_CYC - 1);
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         tick_cnt_reg <= '0;
         now_reg <= '0;
      end
      else
      begin
         tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
         now_reg <= now_reg + STAMP_W'(tick);
      end
   end

   // one queue per class; each entry carries its arrival stamp
   generate
      for (genvar c = 0; c < NUM_CLASS; c++)
      begin : g_queue
         logic [STAMP_W-1:0] age;
         logic [LIM_W-1:0] lat_lim;
         assign q_push[c] = in_valid && push_class == CLASS_W'(c);
         assign q_pop[c] = deq && sel == CLASS_W'(c);
         cps_fifo #(.WIDTH(QW), .DEPTH(QUEUE_DEPTH)) u_fifo (
            .clk(clk),
            .reset(reset),
            .in_valid(q_push[c]),
            .in_ready(q_in_ready[c]),
            .in_data({now_reg, in_desc}),
            .out_valid(q_valid[c]),
            .out_ready(q_pop[c]),
            .out_data(q_data[c])
         );
         // only the head can be the oldest, so only its age is watched
         assign age = now_reg - q_data[c][DESC_W +: STAMP_W];
         assign lat_lim = latency_reg[c*LIM_W +: LIM_W];
         assign urg[c] = q_valid[c] && lat_lim != '0 && age >= lat_lim;
      end
   endgenerate

   assign urg_any = |urg;
   assign budget_ok = burst_reg[cur_reg*LIM_W +: LIM_W] == '0
                   || sent_reg < burst_reg[cur_reg*LIM_W +: LIM_W];

   // overdue first, then the running burst, then the next lower class
   always_comb
   begin
      sel = cur_reg;
      sel_fresh = 1'b0;
      if (urg_any)
      begin
         for (int c = 0; c < NUM_CLASS; c++)
         begin
            if (urg[c])
            begin
               sel = CLASS_W'(c);
            end
         end
      end
      else if (!(q_valid[cur_reg] && budget_ok))
      begin
         // cyclic search from cur-1 down leaves cur as last resort
         for (int k = NUM_CLASS; k >= 1; k--)
         begin
            if (q_valid[cur_reg - CLASS_W'(k)])
            begin
               sel = cur_reg - CLASS_W'(k);
               sel_fresh = 1'b1;
            end
         end
      end
   end

   assign deq = (|q_valid) && (!out_valid_reg || out_ready);

   // burst bookkeeping; an overdue packet jumps in without disturbing it
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cur_reg <= TOP_CLASS;
         sent_reg <= '0;
      end
      else if (deq && !urg_any)
      begin
         if (sel_fresh)
         begin
            cur_reg <= sel;
            sent_reg <= LIM_W'(1);
         end
         else if (sent_reg != '1)
         begin
            sent_reg <= sent_reg + 1'b1;
         end
      end
   end

   // output stage keeps data stable while the transmitter stalls
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         out_valid_reg <= 1'b0;
         out_desc_reg <= '0;
         out_class_reg <= '0;
      end
      else if (!out_valid_reg || out_ready)
      begin
         out_valid_reg <= deq;
         if (deq)
         begin
            out_desc_reg <= q_data[sel][DESC_W-1:0];
            out_class_reg <= sel;
         end
      end
   end
   assign out_valid = out_valid_reg;
   assign out_desc = out_desc_reg;
   assign out_class = out_class_reg;

   // learned-address count; refusal only while security is on
   assign learn_ok = learn_req && (!sec_en || learned_reg < addr_limit);
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         learned_reg <= '0;
      end
      else if (restart && port_cfg_reg[CFG_FLUSH_BIT])
      begin
         learned_reg <= '0;
      end
      else if (learn_ok && learned_reg != '1)
      begin
         learned_reg <= learned_reg + 1'b1;
      end
   end

   // read multiplexer; unmapped addresses read zero
   always_comb
   begin
      rdata_next = '0;
      if (reg_addr == OFF_CLASS_MAP)
      begin
         rdata_next = {16'h0000, class_map_reg};
      end
      else if (reg_addr == OFF_PORT_CFG)
      begin
         rdata_next = port_cfg_reg;
      end
      else if (reg_addr == OFF_BURST)
      begin
         rdata_next = burst_reg;
      end
      else if (reg_addr == OFF_LATENCY)
      begin
         rdata_next = latency_reg;
      end
      else if (reg_addr == OFF_STATUS)
      begin
         rdata_next[ST_NONEMPTY_LSB +: NUM_CLASS] = q_valid;
         rdata_next[ST_URGENT_LSB +: NUM_CLASS] = urg;
         rdata_next[ST_CUR_LSB +: CLASS_W] = cur_reg;
         rdata_next[ST_SENT_LSB +: LIM_W] = sent_reg;
      end
      else if (reg_addr == OFF_LEARNED)
      begin
         rdata_next[LIM_W-1:0] = learned_reg;
      end
      for (int i = 0; i < NUM_ENTRIES; i++)
      begin
         if (ent_space && ent_off[7:4] == 4'(i))
         begin
            if (ent_off[3:2] == ENT_WORD_MAC_LO)
            begin
               rdata_next = ent_mac_reg[i][31:0];
            end
            if (ent_off[3:2] == ENT_WORD_MISC)
            begin
               rdata_next = {1'b0, ent_prio_reg[i], ent_vid_reg[i], ent_mac_reg[i][MAC_W-1:32]};
            end
            if (ent_off[3:2] == ENT_WORD_SEL)
            begin
               rdata_next = {30'h0, ent_sel_reg[i]};
            end
         end
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rdata_reg <= '0;
      end
      else
      begin
         rdata_reg <= reg_rd ? rdata_next : '0;
      end
   end
   assign reg_rdata = rdata_reg;

   // scheduling, classification and learning checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_class_map;
      in_valid && in_ready && !hit && in_has_prio |-> q_push[class_map_reg[{in_prio, 1'b0} +: 2]];
   endproperty
   a_class_map: assert property (p_class_map) else $error("packet queued in wrong class");

   property p_advance;
      deq && !urg_any && sel != cur_reg |-> !q_valid[cur_reg] || !budget_ok;
   endproperty
   a_advance: assert property (p_advance) else $error("class left early");

   property p_burst_cap;
      deq && !urg_any && !sel_fresh && burst_reg[cur_reg*8 +: 8] != 8'h00
         |-> sent_reg < burst_reg[cur_reg*8 +: 8];
   endproperty
   a_burst_cap: assert property (p_burst_cap) else $error("burst limit exceeded");

   property p_drain;
      deq && !urg_any && q_valid[cur_reg] && burst_reg[cur_reg*8 +: 8] == 8'h00 |-> sel == cur_reg;
   endproperty
   a_drain: assert property (p_drain) else $error("zero limit class not drained");

   property p_tick;
      tick |=> !tick [*8] ##0 now_reg == $past(now_reg, 9) + 8'h01;
   endproperty
   a_tick: assert property (p_tick) else $error("latency tick misplaced");

   property p_timer_off;
      latency_reg[7:0] == 8'h00 |-> !urg[0];
   endproperty
   a_timer_off: assert property (p_timer_off) else $error("age timer active at zero");

   property p_urgent;
      deq && urg_any |=> out_valid_reg && $past(urg[sel]) && out_class_reg == $past(sel);
   endproperty
   a_urgent: assert property (p_urgent) else $error("overdue class not served");

   property p_entry;
      in_valid && hit |-> eff_prio == hit_prio && eff_prio <= ent_prio_reg[0] || !ent_match[0];
   endproperty
   a_entry: assert property (p_entry) else $error("entry priority not applied");

   property p_default;
      in_valid && !hit && !in_has_prio |-> eff_prio == port_cfg_reg[2:0];
   endproperty
   a_default: assert property (p_default) else $error("default priority not applied");

   property p_learn_limit;
      learn_req && sec_en && learned_reg >= addr_limit && !restart |-> !learn_ok ##1 $stable(learned_reg);
   endproperty
   a_learn_limit: assert property (p_learn_limit) else $error("address limit ignored");

   property p_hold;
      out_valid_reg && !out_ready |=> out_valid_reg && $stable(out_desc_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("output changed while stalled");

   c_urgent: cover property (deq && urg_any);
   c_advance: cover property (deq && sel_fresh && sel != cur_reg);
   c_refuse: cover property (learn_req && !learn_ok);
   c_full: cover property (in_valid && !in_ready);
endmodule : cps_priority_scheduler
`default_nettype wire

// ===== rtl/cps_pkg.sv
package cps_pkg;
   // register map, one aligned 32-bit word each
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFF_CLASS_MAP = 8'h00;
   localparam logic [7:0] OFF_PORT_CFG = 8'h04;
   localparam logic [7:0] OFF_BURST = 8'h08;
   localparam logic [7:0] OFF_LATENCY = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_LEARNED = 8'h14;
   localparam logic [7:0] OFF_ENTRY_BASE = 8'h40;
   // each priority entry takes a 16-byte slot of three words
   localparam logic [1:0] ENT_WORD_MAC_LO = 2'h0;
   localparam logic [1:0] ENT_WORD_MISC = 2'h1;
   localparam logic [1:0] ENT_WORD_SEL = 2'h2;
   localparam int ENT_VID_LSB = 16;
   localparam int ENT_PRIO_LSB = 28;
   // port configuration fields
   localparam int CFG_DPRIO_LSB = 0;
   localparam int CFG_SEC_EN_BIT = 4;
   localparam int CFG_FLUSH_BIT = 5;
   localparam int CFG_LIMIT_LSB = 8;
   // status fields
   localparam int ST_NONEMPTY_LSB = 0;
   localparam int ST_URGENT_LSB = 4;
   localparam int ST_CUR_LSB = 8;
   localparam int ST_SENT_LSB = 16;
   // widths of the traffic model
   localparam int NUM_PRIO = 8;
   localparam int NUM_CLASS = 4;
   localparam int PRIO_W = 3;
   localparam int CLASS_W = 2;
   localparam int LIM_W = 8;
   localparam int VID_W = 12;
   localparam int MAC_W = 48;
   localparam int STAMP_W = 8;
   // values after reset: priority 0,1 to class 3 down to 6,7 to class 0
   localparam logic [15:0] CLASS_MAP_RST = 16'h05af;
   localparam logic [31:0] PORT_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] BURST_RST = 32'h0000_0000;
   localparam logic [31:0] LATENCY_RST = 32'h0000_0000;
   localparam logic [CLASS_W-1:0] TOP_CLASS = 2'h3;
   // 17 us latency unit in 50 MHz clock cycles
   localparam int TICK_NS = 17000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 10;
   localparam int FIFO_DEPTH = 8;
   // match selector of a priority entry
   typedef enum logic [1:0] {MATCH_OFF, MATCH_DST, MATCH_SRC, MATCH_EITHER} cps_match_e;
endpackage : cps_pkg

// ===== rtl/cps_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module cps_fifo
   import cps_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   // full and empty from the occupancy count
   assign in_ready = count_reg != (AW+1)'(DEPTH);
   assign out_valid = count_reg != '0;
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage needs no reset, only the pointers and the count do
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // explicit wrap lets the depth be any value
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : cps_fifo
`default_nettype wire

// ===== sim/cps_tx_sink.sv
`timescale 1ns/10ps
`default_nettype none
// transmit side: takes at once, every other cycle when slow, never while stalled
module cps_tx_sink
   import cps_pkg::*;
#(
   parameter int DESC_W = 32
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic stall,
   input wire logic slow,
   input wire logic out_valid,
   input wire logic [DESC_W-1:0] out_desc,
   input wire logic [CLASS_W-1:0] out_class,
   output logic out_ready
);
   logic phase_reg;
   logic [CLASS_W+DESC_W-1:0] rx_q[$];
   // slow mode stalls the scheduler every other cycle
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         phase_reg <= 1'b0;
      else
         phase_reg <= !phase_reg;
   end
   assign out_ready = !stall && (!slow || phase_reg);
   // log of descriptors taken, in departure order
   always @(posedge clk)
   begin
      if (!reset && out_valid && out_ready)
         rx_q.push_back({out_class, out_desc});
   end
endmodule : cps_tx_sink
`default_nettype wire

// ===== sim/cps_priority_scheduler_test.sv
`timescale 1ns/10ps
`default_nettype none
module cps_priority_scheduler_test
   import cps_pkg::*;
;
   localparam logic [11:0] V = 12'h064;
   localparam logic [47:0] N = 48'h0123_4567_89ab;
   localparam logic [47:0] M1 = 48'h0a0b_0c0d_0e01;
   localparam logic [47:0] M2 = 48'h0a0b_0c0d_0e02;
   localparam logic [47:0] M3 = 48'h0a0b_0c0d_0e03;
   logic clk;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = '0, reg_rdata, in_desc = '0, out_desc;
   logic reg_wr = 1'b0, reg_rd = 1'b0, in_valid = 1'b0, in_ready, in_has_prio = 1'b0;
   logic [2:0] in_prio = 3'h0;
   logic [11:0] in_vid = 12'h000;
   logic [47:0] in_src_mac = '0, in_dst_mac = '0;
   logic out_valid, out_ready, learn_req = 1'b0, learn_ok, restart = 1'b0;
   logic [1:0] out_class;
   logic stall = 1'b1, slow = 1'b0;
   int cyc = 0, num_errors = 0, num_checks = 0;

   cps_priority_scheduler uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .in_valid, .in_ready, .in_desc, .in_has_prio, .in_prio, .in_vid,
      .in_src_mac, .in_dst_mac, .out_valid, .out_ready, .out_desc, .out_class, .learn_req,
      .learn_ok, .restart);
   cps_tx_sink sink (.clk, .reset, .stall, .slow, .out_valid, .out_desc, .out_class, .out_ready);

   // clock and cycle count since the last reset release
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) cyc <= reset ? 0 : cyc + 1;

   task automatic stop_test;
      if (num_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test

   task automatic chk_word(input string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   // each scenario restarts from reset, so the top class is current
   task automatic do_reset;
      @(posedge clk);
      reset <= 1'b1;
      {stall, slow} <= 2'b10;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      sink.rx_q.delete();
   endtask : do_reset

   task automatic reg_wr_t(input logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_wr_t

   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input string what, logic [7:0] a, logic [31:0] m, logic [31:0] exp);
      @(posedge clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk_word(what, exp, reg_rdata & m);
   endtask : rd_chk

   // one descriptor offered; want low expects a refusal
   task automatic send(input logic h, logic [2:0] p, logic [11:0] v, logic [47:0] s,
                       logic [47:0] d, logic [31:0] id, logic want);
      int n = 0;
      logic ok;
      @(posedge clk);
      in_valid <= 1'b1;
      {in_has_prio, in_prio, in_vid, in_src_mac, in_dst_mac, in_desc} <= {h, p, v, s, d, id};
      do
      begin
         @(negedge clk);
         ok = (in_ready === 1'b1);
         @(posedge clk);
         n++;
      end
      while (!ok && n < (want ? 100 : 1));
      in_valid <= 1'b0;
      chk_word("in_ready", 32'(want), 32'(ok));
   endtask : send

   task automatic expect_pkt(input logic [1:0] c, input logic [31:0] id);
      int n = 0;
      logic [33:0] e;
      while (sink.rx_q.size() == 0 && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      e = (sink.rx_q.size() > 0) ? sink.rx_q.pop_front() : '1;
      chk_word("out_class", 32'(c), 32'(e[33:32]));
      chk_word("out_desc", id, e[31:0]);
   endtask : expect_pkt

   task automatic entry(input int i, logic [47:0] mac, logic [2:0] pri, cps_match_e sel);
      reg_wr_t(OFF_ENTRY_BASE + 8'(i * 16), mac[31:0]);
      reg_wr_t(OFF_ENTRY_BASE + 8'(i * 16 + 4), {1'b0, pri, V, mac[47:32]});
      reg_wr_t(OFF_ENTRY_BASE + 8'(i * 16 + 8), {30'h0, sel});
   endtask : entry

   task automatic pcase(input logic h, logic [2:0] p, logic [11:0] v, logic [47:0] s,
                        logic [47:0] d, logic [1:0] c);
      send(h, p, v, s, d, {30'h0, c}, 1'b1);
      expect_pkt(c, {30'h0, c});
   endtask : pcase

   task automatic learn_chk(input logic exp);
      @(posedge clk);
      learn_req <= 1'b1;
      @(negedge clk);
      chk_word("learn_ok", 32'(exp), 32'(learn_ok));
      @(posedge clk);
      learn_req <= 1'b0;
   endtask : learn_chk

   task automatic pulse_restart;
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
   endtask : pulse_restart

   task automatic t_regs;
      do_reset();
      rd_chk("class_map", OFF_CLASS_MAP, '1, {16'h0, CLASS_MAP_RST});
      rd_chk("port_cfg", OFF_PORT_CFG, '1, PORT_CFG_RST);
      rd_chk("latency", OFF_LATENCY, '1, LATENCY_RST);
      reg_wr_t(OFF_STATUS, 32'hffff_ffff);
      reg_wr_t(8'h20, 32'hffff_ffff);
      rd_chk("status", OFF_STATUS, '1, 32'h0000_0300);
      @(negedge clk);
      chk_word("rdata_idle", 32'h0, reg_rdata);
      rd_chk("unmapped", 8'h20, '1, 32'h0);
      rd_chk("learned", OFF_LEARNED, '1, 32'h0);
      rd_chk("burst", OFF_BURST, '1, BURST_RST);
      reg_wr_t(OFF_BURST, 32'hff00_01ff);
      rd_chk("burst_rw", OFF_BURST, '1, 32'hff00_01ff);
   endtask : t_regs

   // every priority through a scrambled table
   task automatic t_map;
      logic [15:0] m = 16'h1b4e;
      do_reset();
      reg_wr_t(OFF_CLASS_MAP, {16'h0, m});
      stall <= 1'b0;
      for (int p = 0; p < 8; p++)
      begin
         send(1'b1, 3'(p), V, N, N, p, 1'b1);
         expect_pkt(m[2 * p +: 2], p);
      end
   endtask : t_map

   // top class limit 2, class 2 drains, then wrap to the top
   task automatic t_burst;
      int ord[7] = '{1, 2, 4, 5, 6, 7, 3};
      do_reset();
      reg_wr_t(OFF_CLASS_MAP, 32'h0000_e4e4);
      reg_wr_t(OFF_BURST, 32'h0200_0101);
      for (int i = 1; i <= 7; i++)
         send(1'b1, (i < 4) ? 3'h3 : (i < 7) ? 3'h2 : 3'h1, V, N, N, i, 1'b1);
      rd_chk("queues", OFF_STATUS, 32'h0000_030f, 32'h0000_030e);
      @(posedge clk);
      stall <= 1'b0;
      slow <= 1'b1;
      for (int i = 0; i < 7; i++)
         expect_pkt((ord[i] < 4) ? 2'h3 : (ord[i] < 7) ? 2'h2 : 2'h1, ord[i]);
   endtask : t_burst

   task automatic t_prio;
      do_reset();
      reg_wr_t(OFF_CLASS_MAP, 32'h0000_e4e4);
      reg_wr_t(OFF_PORT_CFG, 32'h0000_0005);
      entry(0, M1, 3'h2, MATCH_DST);
      entry(1, M2, 3'h3, MATCH_SRC);
      entry(2, M3, 3'h1, MATCH_EITHER);
      stall <= 1'b0;
      pcase(1'b0, 3'h0, V, N, N, 2'h1);
      pcase(1'b1, 3'h4, V, N, N, 2'h0);
      pcase(1'b1, 3'h4, V, N, M1, 2'h2);
      pcase(1'b1, 3'h4, V, M1, N, 2'h0);
      pcase(1'b1, 3'h4, V, M2, N, 2'h3);
      pcase(1'b1, 3'h4, V, N, M2, 2'h0);
      pcase(1'b1, 3'h4, V, M3, N, 2'h1);
      pcase(1'b1, 3'h4, V, N, M3, 2'h1);
      pcase(1'b1, 3'h4, 12'h065, N, M1, 2'h0);
      pcase(1'b1, 3'h4, V, M2, M1, 2'h2);
      pcase(1'b0, 3'h0, V, N, M1, 2'h2);
   endtask : t_prio

   // top class fills behind a stalled sink while a class 0 packet ages
   task automatic t_latency(input logic [7:0] lat);
      do_reset();
      reg_wr_t(OFF_LATENCY, {24'h0, lat});
      for (int i = 0; i < 9; i++)
         send(1'b1, 3'h0, V, N, N, i, 1'b1);
      send(1'b1, 3'h0, V, N, N, 9, 1'b0);
      send(1'b1, 3'h7, V, N, N, 10, 1'b1);
      while (cyc < 830) @(negedge clk);
      rd_chk("overdue_early", OFF_STATUS, 32'h10, 32'h0);
      while (cyc < 880) @(negedge clk);
      rd_chk("overdue", OFF_STATUS, 32'h10, (lat != 0) ? 32'h10 : 32'h0);
      @(posedge clk);
      stall <= 1'b0;
      expect_pkt(2'h3, 0);
      if (lat != 0)
         expect_pkt(2'h0, 10);
      for (int i = 1; i < 9; i++)
         expect_pkt(2'h3, i);
      if (lat == 0)
         expect_pkt(2'h0, 10);
   endtask : t_latency

   task automatic t_learn;
      do_reset();
      reg_wr_t(OFF_PORT_CFG, 32'h0000_0230);
      learn_chk(1'b1);
      learn_chk(1'b1);
      learn_chk(1'b0);
      rd_chk("learned", OFF_LEARNED, 32'hff, 32'h2);
      pulse_restart();
      rd_chk("flushed", OFF_LEARNED, 32'hff, 32'h0);
      reg_wr_t(OFF_PORT_CFG, 32'h0000_0210);
      learn_chk(1'b1);
      pulse_restart();
      rd_chk("kept", OFF_LEARNED, 32'hff, 32'h1);
      reg_wr_t(OFF_PORT_CFG, 32'h0000_0000);
      learn_chk(1'b1);
      learn_chk(1'b1);
   endtask : t_learn

   initial
   begin
      t_regs();
      t_map();
      t_burst();
      t_prio();
      t_latency(8'h01);
      t_latency(8'h00);
      t_learn();
      stop_test();
   end

   // a run takes some two thousand cycles
   initial
   begin
      #400000;
      num_errors++;
      stop_test();
   end
endmodule : cps_priority_scheduler_test
`default_nettype wire
